/* thermal_monitor_config_regs.v */
/*
  Configuration register pair of a thermal and fan monitor: fan pulse count
  setting and temperature format / pin configuration, plus the decode of
  these settings into the datapath they steer.
  Assumes a serial management front end that delivers a one-cycle write
  strobe with address and data, and a combinational read address; the
  lock bit arrives as a level from another register on the same clock.
*/
`timescale 1ns/1ps
`include "thermal_cfg_defines.vh"

module thermal_monitor_config_regs (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_wr_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wr_data,
  output reg [7:0] o_rd_data,
  input wire i_lock,
  input wire [7:0] i_remote1_temp,
  input wire [7:0] i_local_temp,
  input wire [7:0] i_remote2_temp,
  input wire [7:0] i_remote1_limit,
  input wire [7:0] i_local_limit,
  input wire [7:0] i_remote2_limit,
  input wire [7:0] i_remote1_offset,
  input wire [7:0] i_local_offset,
  input wire [7:0] i_remote2_offset,
  input wire i_spare_io_six_in,
  output reg o_spare_io_six_out,
  output reg o_spare_io_six_oe,
  input wire i_spare_io_six_level,
  output reg o_spare_io_six_in_value,
  output reg o_voltage_id_pin_select,
  input wire i_overtemp_pin_in,
  output reg o_overtemp_pin_out,
  output reg o_overtemp_pin_oe,
  output reg o_overtemp_timer_in,
  output reg [2:0] o_fan_pulse_count_field_pulses,
  output reg [2:0] o_fan2_pulses,
  output reg [2:0] o_fan3_pulses,
  output reg [2:0] o_fan4_pulses,
  output reg signed [9:0] o_remote1_offset_half,
  output reg signed [9:0] o_local_offset_half,
  output reg signed [9:0] o_remote2_offset_half,
  output reg [7:0] o_remote1_temp_twos,
  output reg [7:0] o_local_temp_twos,
  output reg [7:0] o_remote2_temp_twos
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg [7:0] fan_pulse_count_cfg_q;
  reg [7:0] temp_format_pin_cfg_q;
  reg [2:0] pin_sync_q;
  reg [2:0] ot_sync_q;
  reg spare_in_q;
  reg ot_in_q;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      fan_pulse_count_cfg_q <= `RST_FAN_PULSE_COUNT_CFG;
      temp_format_pin_cfg_q <= `RST_TEMP_FORMAT_PIN_CFG;
    end else if (i_wr_en) begin
      if (i_addr == `ADDR_FAN_PULSE_COUNT_CFG)
        fan_pulse_count_cfg_q <= i_wr_data;
      // A locked register ignores writes silently; nothing is reported.
      if (i_addr == `ADDR_TEMP_FORMAT_PIN_CFG && !i_lock)
        temp_format_pin_cfg_q <= i_wr_data;
    end
  end

  always @* begin
    case (i_addr)
      `ADDR_FAN_PULSE_COUNT_CFG: o_rd_data = fan_pulse_count_cfg_q;
      `ADDR_TEMP_FORMAT_PIN_CFG: o_rd_data = temp_format_pin_cfg_q;
      default: o_rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  // A change is accepted only when the second and third stages agree.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      pin_sync_q <= 3'h0;
      ot_sync_q <= 3'h7;
      spare_in_q <= 1'b0;
      ot_in_q <= 1'b1;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], i_spare_io_six_level};
      ot_sync_q <= {ot_sync_q[1:0], i_overtemp_pin_in};
      if (pin_sync_q[1] == pin_sync_q[2])
        spare_in_q <= pin_sync_q[2];
      if (ot_sync_q[1] == ot_sync_q[2])
        ot_in_q <= ot_sync_q[2];
    end
  end

  // ----------------------------------------------------------------
  // Decode of settings
  // ----------------------------------------------------------------
  wire twos_complement_select = temp_format_pin_cfg_q[`BIT_TWOS_COMPLEMENT_SELECT];
  wire offset_range_select = temp_format_pin_cfg_q[`BIT_OFFSET_RANGE_SELECT];
  wire spare_io_six_direction = temp_format_pin_cfg_q[`BIT_SPARE_IO_SIX_DIRECTION];
  wire spare_io_six_polarity = temp_format_pin_cfg_q[`BIT_SPARE_IO_SIX_POLARITY];
  wire voltage_id_pin_select = temp_format_pin_cfg_q[`BIT_VOLTAGE_ID_PIN_SELECT];
  wire [2:0] ot_enable = temp_format_pin_cfg_q[7:5];

  // Converts a stored reading to twos complement; the stored value itself
  // is never rewritten, so flipping the format bit is instantly reversible.
  function [7:0] to_twos;
    input [7:0] raw;
    input twos;
    begin
      to_twos = twos ? raw : (raw - `OFFSET64_BIAS);
    end
  endfunction

  // Offset in half-degree units: half steps or whole-degree steps.
  function signed [9:0] offset_half;
    input [7:0] raw;
    input wide;
    begin
      if (wide)
        offset_half = {raw[7], raw, 1'b0};
      else
        offset_half = {raw[7], raw[7], raw};
    end
  endfunction

  function limit_off;
    input [7:0] lim;
    input twos;
    begin
      limit_off = twos ? (lim == `LIMIT_OFF_TWOS)
                       : (lim == `LIMIT_OFF_OFFSET64);
    end
  endfunction

  wire [7:0] r1_t = to_twos(i_remote1_temp, twos_complement_select);
  wire [7:0] lo_t = to_twos(i_local_temp, twos_complement_select);
  wire [7:0] r2_t = to_twos(i_remote2_temp, twos_complement_select);
  wire [7:0] r1_l = to_twos(i_remote1_limit, twos_complement_select);
  wire [7:0] lo_l = to_twos(i_local_limit, twos_complement_select);
  wire [7:0] r2_l = to_twos(i_remote2_limit, twos_complement_select);

  wire r1_hot = ot_enable[0] && !limit_off(i_remote1_limit, twos_complement_select) &&
                ($signed(r1_t) > $signed(r1_l));
  wire lo_hot = ot_enable[1] && !limit_off(i_local_limit, twos_complement_select) &&
                ($signed(lo_t) > $signed(lo_l));
  wire r2_hot = ot_enable[2] && !limit_off(i_remote2_limit, twos_complement_select) &&
                ($signed(r2_t) > $signed(r2_l));

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_spare_io_six_out <= 1'b0;
      o_spare_io_six_oe <= 1'b0;
      o_spare_io_six_in_value <= 1'b0;
      o_voltage_id_pin_select <= 1'b0;
      o_overtemp_pin_out <= 1'b0;
      o_overtemp_pin_oe <= 1'b0;
      o_overtemp_timer_in <= 1'b0;
      o_fan_pulse_count_field_pulses <= 3'h2;
      o_fan2_pulses <= 3'h2;
      o_fan3_pulses <= 3'h2;
      o_fan4_pulses <= 3'h2;
      o_remote1_offset_half <= 10'sh000;
      o_local_offset_half <= 10'sh000;
      o_remote2_offset_half <= 10'sh000;
      o_remote1_temp_twos <= 8'h00;
      o_local_temp_twos <= 8'h00;
      o_remote2_temp_twos <= 8'h00;
    end else begin
      // Active level follows polarity; the pin is driven only as an output.
      o_spare_io_six_oe <= spare_io_six_direction;
      o_spare_io_six_out <= spare_io_six_polarity ? i_spare_io_six_in
                                                  : ~i_spare_io_six_in;
      o_spare_io_six_in_value <= spare_in_q;
      o_voltage_id_pin_select <= voltage_id_pin_select;
      // Overtemp pin is active low, open drain: drive low only when hot.
      o_overtemp_pin_out <= 1'b0;
      o_overtemp_pin_oe <= r1_hot | lo_hot | r2_hot;
      o_overtemp_timer_in <= ~ot_in_q;
      o_fan_pulse_count_field_pulses <= {1'b0, fan_pulse_count_cfg_q[1:0]} + 3'h1;
      o_fan2_pulses <= {1'b0, fan_pulse_count_cfg_q[3:2]} + 3'h1;
      o_fan3_pulses <= {1'b0, fan_pulse_count_cfg_q[5:4]} + 3'h1;
      o_fan4_pulses <= {1'b0, fan_pulse_count_cfg_q[7:6]} + 3'h1;
      o_remote1_offset_half <= offset_half(i_remote1_offset, offset_range_select);
      o_local_offset_half <= offset_half(i_local_offset, offset_range_select);
      o_remote2_offset_half <= offset_half(i_remote2_offset, offset_range_select);
      o_remote1_temp_twos <= r1_t;
      o_local_temp_twos <= lo_t;
      o_remote2_temp_twos <= r2_t;
    end
  end

endmodule

/* thermal_cfg_defines.vh */
/*
  Register offsets, field positions, reset values and encodings for the
  thermal monitor configuration register pair.
  Assumes it is included by bare name from the design file that uses it.
*/
// Overview of operation
// - Format bit one selects twos complement range.
// - Format bit zero selects offset-64 range.
// - New format applies immediately to all temperatures.
// - Offset range zero: half-degree steps, -63..+64.
// - Offset range one: one-degree steps, -63..+127.
// - Offset range governs all three offset registers.
// - Bit 2 sets spare pin direction.
// - Bit 3 sets spare output polarity.
// - Bit 4 selects voltage-ID or general I/O.
// - Bit 5 lets remote one drive overtemp.
// - Bit 6 lets local channel drive overtemp.
// - Bit 7 lets remote two drive overtemp.
// - Limit -64 disables channel in offset-64.
// - Limit -128 disables channel in twos complement.
// - Lock bit makes config register read-only.
// - Config register resets to 0x01.
// - Pulse count register resets to 0x55.
// - Two-bit fan codes select 1 to 4 pulses.
`ifndef THERMAL_CFG_DEFINES_VH
`define THERMAL_CFG_DEFINES_VH

`define ADDR_FAN_PULSE_COUNT_CFG 8'h7b
`define ADDR_TEMP_FORMAT_PIN_CFG 8'h7c
`define RST_FAN_PULSE_COUNT_CFG 8'h55
`define RST_TEMP_FORMAT_PIN_CFG 8'h01

`define BIT_TWOS_COMPLEMENT_SELECT 0
`define BIT_OFFSET_RANGE_SELECT 1
`define BIT_SPARE_IO_SIX_DIRECTION 2
`define BIT_SPARE_IO_SIX_POLARITY 3
`define BIT_VOLTAGE_ID_PIN_SELECT 4
`define BIT_REMOTE1_OVERTEMP_ENABLE 5
`define BIT_LOCAL_OVERTEMP_ENABLE 6
`define BIT_REMOTE2_OVERTEMP_ENABLE 7

`define LIMIT_OFF_OFFSET64 8'h00
`define LIMIT_OFF_TWOS 8'h80
`define OFFSET64_BIAS 8'h40

`endif

/* thermal_cfg_asserts.sv */
/*
  Concurrent checks for the thermal monitor configuration register pair.
  Assumes it is bound to the design top and sees only its ports.
*/
`timescale 1ns/1ps
`include "thermal_cfg_defines.vh"
module thermal_cfg_asserts (
  input logic i_clk,
  input logic i_sys_rst,
  input logic i_wr_en,
  input logic [7:0] i_addr,
  input logic [7:0] i_wr_data,
  input logic [7:0] o_rd_data,
  input logic i_lock,
  input logic [7:0] i_local_temp,
  input logic i_spare_io_six_in,
  input logic o_spare_io_six_out,
  input logic o_spare_io_six_oe,
  input logic o_voltage_id_pin_select,
  input logic [2:0] o_fan_pulse_count_field_pulses,
  input logic [2:0] o_fan4_pulses,
  input logic [7:0] o_local_temp_twos
);
  // ----------------------------------------
  // Write sequences and their consequences
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_cfg_wr;
    i_wr_en && i_addr == `ADDR_TEMP_FORMAT_PIN_CFG && !i_lock;
  endsequence
  sequence s_fan_wr;
    i_wr_en && i_addr == `ADDR_FAN_PULSE_COUNT_CFG;
  endsequence
  sequence s_locked_wr;
    i_wr_en && i_addr == `ADDR_TEMP_FORMAT_PIN_CFG && i_lock;
  endsequence
  chk_dir_follows_bit: assert property (
    s_cfg_wr |-> ##2 o_spare_io_six_oe == $past(i_wr_data[2], 2))
    else $error("spare pin direction does not follow its bit");
  chk_polarity_applied: assert property (
    s_cfg_wr |-> ##2 o_spare_io_six_out ==
      ($past(i_spare_io_six_in) ~^ $past(i_wr_data[3], 2)))
    else $error("spare pin output polarity wrong");
  chk_vid_select_bit: assert property (
    s_cfg_wr |-> ##2 o_voltage_id_pin_select == $past(i_wr_data[4], 2))
    else $error("voltage id select does not follow its bit");
  chk_offset64_convert: assert property (
    (s_cfg_wr and i_wr_data[0] == 1'b0) |->
      ##2 o_local_temp_twos == $past(i_local_temp) - `OFFSET64_BIAS)
    else $error("offset-64 reading not converted");
  chk_twos_passthrough: assert property (
    (s_cfg_wr and i_wr_data[0] == 1'b1) |-> ##2 o_local_temp_twos == $past(i_local_temp))
    else $error("twos reading altered");
  chk_lock_holds_cfg: assert property (
    s_locked_wr ##1 i_addr == `ADDR_TEMP_FORMAT_PIN_CFG |-> $stable(o_rd_data))
    else $error("locked register changed");
  chk_cfg_readback: assert property (
    s_cfg_wr ##1 i_addr == `ADDR_TEMP_FORMAT_PIN_CFG |-> o_rd_data == $past(i_wr_data))
    else $error("config readback wrong");
  chk_fan_code_map: assert property (
    s_fan_wr |-> ##2 o_fan_pulse_count_field_pulses == {1'b0, $past(i_wr_data[1:0], 2)} + 3'h1 &&
      o_fan4_pulses == {1'b0, $past(i_wr_data[7:6], 2)} + 3'h1)
    else $error("fan pulse count wrong");
  chk_reset_defaults: assert property (
    $fell(i_sys_rst) |-> o_fan_pulse_count_field_pulses == 3'h2 && o_fan4_pulses == 3'h2 && !o_spare_io_six_oe)
    else $error("outputs wrong after reset");
endmodule
bind thermal_monitor_config_regs thermal_cfg_asserts chk_inst (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst),
  .i_wr_en(i_wr_en), .i_addr(i_addr), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data), .i_lock(i_lock),
  .i_local_temp(i_local_temp), .i_spare_io_six_in(i_spare_io_six_in),
  .o_spare_io_six_out(o_spare_io_six_out), .o_spare_io_six_oe(o_spare_io_six_oe),
  .o_voltage_id_pin_select(o_voltage_id_pin_select), .o_fan_pulse_count_field_pulses(o_fan_pulse_count_field_pulses),
  .o_fan4_pulses(o_fan4_pulses), .o_local_temp_twos(o_local_temp_twos));

/* thermal_monitor_config_regs_tb.sv */
/*
  Self-checking bench for the thermal monitor configuration register pair.
  Assumes the design and its defines header are compiled alongside.
*/
`timescale 1ns/1ps
`include "thermal_cfg_defines.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value at %0t got %h exp %h", $time, a, e); end end
module thermal_monitor_config_regs_tb;
  // ----------------------------------------
  // Stimulus, tasks and tests
  // ----------------------------------------
  logic i_clk = 0, i_sys_rst = 1, wr_en = 0, lock = 0, sp_in = 0, sp_lvl = 0, ot_in = 1;
  logic [7:0] addr = 0, wdata = 0, t [3], l [3], f [3];
  wire [7:0] rd, tw [3];
  wire signed [9:0] oh [3];
  wire [2:0] fp [4];
  wire so, soe, siv, voltage_id_inputs, oto, otoe, tmr;
  int n_fail = 0, total_checks = 0, cyc = 0;
  always #2.5 i_clk = ~i_clk;
  thermal_monitor_config_regs thermal_monitor_config_regs_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_wr_en(wr_en), .i_addr(addr), .i_wr_data(wdata), .o_rd_data(rd), .i_lock(lock),
    .i_remote1_temp(t[0]), .i_local_temp(t[1]), .i_remote2_temp(t[2]), .i_remote1_limit(l[0]),
    .i_local_limit(l[1]), .i_remote2_limit(l[2]), .i_remote1_offset(f[0]), .i_local_offset(f[1]),
    .i_remote2_offset(f[2]), .i_spare_io_six_in(sp_in), .o_spare_io_six_out(so),
    .o_spare_io_six_oe(soe), .i_spare_io_six_level(sp_lvl), .o_spare_io_six_in_value(siv),
    .o_voltage_id_pin_select(voltage_id_inputs), .i_overtemp_pin_in(ot_in), .o_overtemp_pin_out(oto),
    .o_overtemp_pin_oe(otoe), .o_overtemp_timer_in(tmr), .o_fan_pulse_count_field_pulses(fp[0]),
    .o_fan2_pulses(fp[1]), .o_fan3_pulses(fp[2]), .o_fan4_pulses(fp[3]),
    .o_remote1_offset_half(oh[0]), .o_local_offset_half(oh[1]), .o_remote2_offset_half(oh[2]),
    .o_remote1_temp_twos(tw[0]), .o_local_temp_twos(tw[1]), .o_remote2_temp_twos(tw[2]));
  task close_out;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Derived outputs lag the register by one cycle, so each write waits two edges.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) begin addr <= a; wdata <= d; wr_en <= 1'b1; end
    @(posedge i_clk) wr_en <= 1'b0;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk) addr <= a;
    @(negedge i_clk);
    `CHK(rd, e)
  endtask
  task lim(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    @(posedge i_clk) begin l[0] <= a; l[1] <= b; l[2] <= c; end
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      close_out;
    end
  end
  initial begin
    t = '{8'h50, 8'h50, 8'h50};
    f = '{8'h05, 8'h05, 8'h05};
    l = '{8'h40, 8'h60, 8'h40};
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (3) @(negedge i_clk);
    for (int k = 0; k < 4; k++) `CHK(fp[k], 3'h2)
    `CHK(tw[1], 8'h50)
    rd_chk(`ADDR_FAN_PULSE_COUNT_CFG, 8'h55);
    rd_chk(`ADDR_TEMP_FORMAT_PIN_CFG, 8'h01);
    rd_chk(8'h7a, 8'h00);
    wr(`ADDR_FAN_PULSE_COUNT_CFG, 8'he4);
    for (int k = 0; k < 4; k++) `CHK(fp[k], 3'(k + 1))
    $display("test reset and fan codes done");
    wr(`ADDR_TEMP_FORMAT_PIN_CFG, 8'h00);
    for (int k = 0; k < 3; k++) `CHK(tw[k], 8'h10)
    for (int k = 0; k < 3; k++) `CHK(oh[k], 10'h005)
    rd_chk(`ADDR_TEMP_FORMAT_PIN_CFG, 8'h00);
    wr(`ADDR_TEMP_FORMAT_PIN_CFG, 8'h03);
    for (int k = 0; k < 3; k++) `CHK(tw[k], 8'h50)
    for (int k = 0; k < 3; k++) `CHK(oh[k], 10'h00a)
    $display("test format and offsets done");
    for (int k = 0; k < 3; k++) begin
      wr(`ADDR_TEMP_FORMAT_PIN_CFG, (8'h20 << k) | 8'h01);
      `CHK(otoe, k != 1)
    end
    lim(8'h00, 8'h00, 8'h00);
    wr(`ADDR_TEMP_FORMAT_PIN_CFG, 8'he1);
    `CHK(otoe, 1'b1)
    wr(`ADDR_TEMP_FORMAT_PIN_CFG, 8'he0);
    `CHK(otoe, 1'b0)
    lim(8'h80, 8'h80, 8'h80);
    wr(`ADDR_TEMP_FORMAT_PIN_CFG, 8'he1);
    `CHK(otoe, 1'b0)
    @(posedge i_clk) ot_in <= 1'b0;
    repeat (6) @(negedge i_clk);
    `CHK(tmr, 1'b1)
    `CHK(oto, 1'b0)
    $display("test overtemp done");
    @(posedge i_clk) begin sp_in <= 1'b1; sp_lvl <= 1'b1; end
    // The pin level needs four edges through the filter before it shows.
    repeat (3) @(posedge i_clk);
    wr(`ADDR_TEMP_FORMAT_PIN_CFG, 8'h1d);
    `CHK({soe, so, voltage_id_inputs, siv}, 4'hf)
    wr(`ADDR_TEMP_FORMAT_PIN_CFG, 8'h15);
    `CHK({soe, so, voltage_id_inputs}, 3'h5)
    wr(`ADDR_TEMP_FORMAT_PIN_CFG, 8'h01);
    `CHK({soe, voltage_id_inputs}, 2'h0)
    $display("test spare pin done");
    @(posedge i_clk) lock <= 1'b1;
    wr(`ADDR_TEMP_FORMAT_PIN_CFG, 8'hff);
    rd_chk(`ADDR_TEMP_FORMAT_PIN_CFG, 8'h01);
    wr(`ADDR_FAN_PULSE_COUNT_CFG, 8'h00);
    rd_chk(`ADDR_FAN_PULSE_COUNT_CFG, 8'h00);
    $display("test lock done");
    close_out;
  end
endmodule
